// >>> mtmr_pkg.sv
// What this block does
// - host access to address table is read-only
// - bit 71 flags empty table, resets to one
// - bits 70..61 give occupancy minus one
// - every entry read returns occupancy and empty flag
// - bits 60..59 carry the 2-bit aging stamp
// - bits 58..56 give learning port, resets zero
// - bit 55 set while entry not ready
// - nine data bytes, top byte first, fid, address
// - trigger write fetches selected entry into data
// - separate counter set for every port
// - counters 0,1 add received octets by priority
// - counters 2,3,6 runts, fragments, symbol errors
// - counter 4 counts good oversized frames
// - counter 5 counts jabber frames
// - counters 7,8 checksum and misaligned errors
// - counters 9,A control and pause frames
// - counters B,C,D good broadcast, multicast, unicast
// - counters E..13 bin frames by length
// - counters 14,15 add transmitted good octets
// - counter 16 counts late collisions
// - counters 17,18 transmitted pause and broadcast
// - port blocks 32 offsets apart, same layout
// - counter word: overflow, valid, 30-bit value
// - reading a counter clears it
package mtmr_pkg;
   localparam int NPORTS = 5;
   localparam int NCTRS  = 25;
   localparam int CNT_W  = 30;
   localparam int LEN_W  = 11;
   localparam int ADDR_W = 7;
   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_SELECT     = 7'h6E;
   localparam logic [ADDR_W-1:0] IDX_TRIGGER    = 7'h6F;
   localparam logic [ADDR_W-1:0] IDX_DATA_FIRST = 7'h70;
   localparam logic [ADDR_W-1:0] IDX_DATA_LAST  = 7'h78;
   localparam logic [ADDR_W-1:0] IDX_CONFIG     = 7'h79;
   // select codes
   localparam logic [7:0] SEL_DYN_MASK = 8'hFC;
   localparam logic [7:0] SEL_DYN_CODE = 8'h18;
   localparam logic [7:0] SEL_MIB_CODE = 8'h1C;
   localparam logic [7:0] SEL_RESET    = 8'h00;
   localparam logic [7:0] CFG_RESET    = 8'h00;
   localparam int CFG_LONG_BIT = 0;
   localparam int CFG_HUGE_BIT = 1;
   // entry layout
   localparam int EMPTY_BIT = 71;
   localparam int NRDY_BIT  = 55;
   localparam logic [71:0] ENTRY_RESET = 72'h80_0000_0000_0000_0000;
   // counter word layout and port block spacing
   localparam int MIB_PORT_LSB = 5;
   localparam int MIB_OVF_BIT  = 31;
   // frame length limits
   localparam logic [LEN_W-1:0] LEN_MIN      = 11'h040;
   localparam logic [LEN_W-1:0] LEN_BIN1_MAX = 11'h07F;
   localparam logic [LEN_W-1:0] LEN_BIN2_MAX = 11'h0FF;
   localparam logic [LEN_W-1:0] LEN_BIN3_MAX = 11'h1FF;
   localparam logic [LEN_W-1:0] LEN_BIN4_MAX = 11'h3FF;
   localparam logic [LEN_W-1:0] LEN_STD_MAX  = 11'h5F2;
   localparam logic [LEN_W-1:0] LEN_LONG_MAX = 11'h600;
   localparam logic [LEN_W-1:0] LEN_HUGE_MAX = 11'h77C;
   typedef enum logic [0:0] {FETCH_IDLE, FETCH_WAIT} mtmr_fetch_t;
endpackage : mtmr_pkg

// >>> mtmr_readout.sv
module mtmr_readout (
   // clock and reset
   input  wire  logic                                      core_clk,
   input  wire  logic                                      rst,
   // register bus
   input  wire  logic [mtmr_pkg::ADDR_W-1:0]               address,
   input  wire  logic                                      read,
   input  wire  logic                                      write,
   input  wire  logic [31:0]                               writedata,
   input  wire  logic [3:0]                                byteenable,
   output logic       [31:0]                               readdata,
   output logic                                            waitrequest,
   // address table read port
   output logic                                            tableRdReq,
   output logic       [9:0]                                tableRdIndex,
   input  wire  logic                                      tableRdAck,
   input  wire  logic [1:0]                                tableRdStamp,
   input  wire  logic [2:0]                                tableRdPort,
   input  wire  logic [6:0]                                tableRdFid,
   input  wire  logic [47:0]                               tableRdMac,
   input  wire  logic [10:0]                               tableCount,
   // receive frame events, one pulse per finished frame
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    rxDone,
   input  wire  logic [mtmr_pkg::NPORTS-1:0][mtmr_pkg::LEN_W-1:0] rxLength,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    rxHighPrio,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    rxCrcOk,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    rxSymbolBad,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    rxMisaligned,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    rxControl,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    rxPauseOk,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    rxBcast,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    rxMcast,
   // transmit frame events
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    txDone,
   input  wire  logic [mtmr_pkg::NPORTS-1:0][mtmr_pkg::LEN_W-1:0] txLength,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    txHighPrio,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    txGood,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    txPause,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    txBcast,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    txMcast,
   input  wire  logic [mtmr_pkg::NPORTS-1:0]                    txLateCollide
);
   import mtmr_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]             selectReg;
   logic [7:0]             triggerReg;
   logic [7:0]             configReg;
   logic [71:0]            dataWord;
   mtmr_fetch_t            fetchState;
   logic [CNT_W-1:0]       mibCount [NPORTS][NCTRS];
   logic                   mibOvf   [NPORTS][NCTRS];
   logic [LEN_W-1:0]       incAmt   [NPORTS][NCTRS];

   logic                   busReq;
   logic                   wrStrobe;
   logic                   trigWrite;
   logic                   dynSelected;
   logic                   mibSelected;
   logic [7:0]             rdByte;
   logic                   occEmpty;
   logic [9:0]             occField;
   logic [10:0]            occMinusOne;
   logic [2:0]             clrPort;
   logic [4:0]             clrCtr;
   logic                   clrHit;
   logic [31:0]            mibWord;
   logic [LEN_W-1:0]       sizeLimit;

   function automatic logic [LEN_W-1:0] one(input logic c);
      return c ? LEN_W'(1) : '0;
   endfunction : one

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   // one wait cycle: data is loaded at the first edge, the access ends at the second
   assign busReq    = read | write;
   assign wrStrobe  = write & ~waitrequest & byteenable[0];
   assign trigWrite = wrStrobe && (address == IDX_TRIGGER);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         waitrequest <= 1'b1;
         readdata    <= '0;
      end else if (busReq && waitrequest) begin
         waitrequest <= 1'b0;
         readdata    <= {24'h00_0000, rdByte};
      end else begin
         waitrequest <= 1'b1;
      end
   end

   always_comb begin
      rdByte = 8'h00;
      if (address >= IDX_DATA_FIRST && address <= IDX_DATA_LAST) begin
         rdByte = dataWord[8*(IDX_DATA_LAST - address) +: 8];
      end else if (address == IDX_SELECT) begin
         rdByte = selectReg;
      end else if (address == IDX_TRIGGER) begin
         rdByte = triggerReg;
      end else if (address == IDX_CONFIG) begin
         rdByte = configReg;
      end
   end

   // data bytes take no writes: the table stays the hardware's alone
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         selectReg <= SEL_RESET;
         configReg <= CFG_RESET;
      end else if (wrStrobe && address == IDX_SELECT) begin
         selectReg <= writedata[7:0];
      end else if (wrStrobe && address == IDX_CONFIG) begin
         configReg <= writedata[7:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         triggerReg <= 8'h00;
      end else if (trigWrite) begin
         triggerReg <= writedata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // address table fetch
   // ----------------------------------------------------------------
   assign dynSelected = (selectReg & SEL_DYN_MASK) == SEL_DYN_CODE;
   assign mibSelected = selectReg == SEL_MIB_CODE;
   assign occEmpty    = tableCount == 11'h000;
   assign occMinusOne = tableCount - 11'h001;
   assign occField    = occEmpty ? 10'h000 : occMinusOne[9:0];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fetchState   <= FETCH_IDLE;
         tableRdReq   <= 1'b0;
         tableRdIndex <= 10'h000;
      end else begin
         case (fetchState)
            FETCH_IDLE: begin
               if (trigWrite && dynSelected) begin
                  fetchState   <= FETCH_WAIT;
                  tableRdReq   <= 1'b1;
                  tableRdIndex <= {selectReg[1:0], writedata[7:0]};
               end
            end
            FETCH_WAIT: begin
               if (trigWrite && dynSelected) begin
                  tableRdIndex <= {selectReg[1:0], writedata[7:0]};
               end else if (trigWrite) begin
                  fetchState <= FETCH_IDLE;
                  tableRdReq <= 1'b0;
               end else if (tableRdAck) begin
                  fetchState <= FETCH_IDLE;
                  tableRdReq <= 1'b0;
               end
            end
            default: begin
               fetchState <= FETCH_IDLE;
               tableRdReq <= 1'b0;
            end
         endcase
      end
   end

   // data word changes only on a trigger or on the answer to that trigger
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dataWord <= ENTRY_RESET;
      end else if (trigWrite && dynSelected) begin
         dataWord           <= '0;
         dataWord[71:55]    <= {occEmpty, occField, 5'b0_0000, 1'b1};
      end else if (trigWrite && mibSelected) begin
         dataWord <= {40'h00_0000_0000, mibWord};
      end else if (fetchState == FETCH_WAIT && tableRdAck && !trigWrite) begin
         dataWord <= {occEmpty, occField, tableRdStamp, tableRdPort,
                      1'b0, tableRdFid, tableRdMac};
      end
   end

   // ----------------------------------------------------------------
   // counter read selection
   // ----------------------------------------------------------------
   assign clrPort = writedata[7:MIB_PORT_LSB];
   assign clrCtr  = writedata[MIB_PORT_LSB-1:0];
   assign clrHit  = trigWrite && mibSelected && (clrPort < 3'(NPORTS)) && (clrCtr < 5'(NCTRS));

   always_comb begin
      mibWord = 32'h0000_0000;
      if (clrHit) begin
         mibWord = {mibOvf[clrPort][clrCtr], 1'b1,
                    mibCount[clrPort][clrCtr]};
      end else if (clrPort < 3'(NPORTS)) begin
         mibWord[MIB_OVF_BIT-1] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // per-port counter increments
   // ----------------------------------------------------------------
   assign sizeLimit = configReg[CFG_LONG_BIT] ? LEN_LONG_MAX : LEN_STD_MAX;

   always_comb begin
      logic             good;
      logic             inRange;
      logic             huge;
      logic [LEN_W-1:0] len;
      good    = 1'b0;
      inRange = 1'b0;
      huge    = configReg[CFG_HUGE_BIT];
      len     = '0;
      for (int p = 0; p < NPORTS; p++) begin
         len     = rxLength[p];
         good    = rxCrcOk[p] & ~rxSymbolBad[p] & ~rxMisaligned[p];
         inRange = (len >= LEN_MIN) && (len <= sizeLimit);
         for (int c = 0; c < NCTRS; c++) begin
            incAmt[p][c] = '0;
         end
         if (rxDone[p]) begin
            incAmt[p][0]  = rxHighPrio[p] ? '0 : len;
            incAmt[p][1]  = rxHighPrio[p] ? len : '0;
            incAmt[p][2]  = one(len < LEN_MIN && good);
            incAmt[p][3]  = one(len < LEN_MIN && !good);
            incAmt[p][4]  = one(len > sizeLimit && good);
            incAmt[p][5]  = huge ? one(len > LEN_HUGE_MAX)
                                 : one(len > sizeLimit && !good);
            incAmt[p][6]  = one(inRange && rxSymbolBad[p]);
            incAmt[p][7]  = one(inRange && !rxCrcOk[p] && !rxMisaligned[p]);
            incAmt[p][8]  = one(inRange && !rxCrcOk[p] && rxMisaligned[p]);
            incAmt[p][9]  = one(rxControl[p]);
            incAmt[p][10] = one(rxPauseOk[p] && rxControl[p] && rxCrcOk[p]
                                && len >= LEN_MIN);
            incAmt[p][11] = one(good && rxBcast[p] && !rxMcast[p]);
            incAmt[p][12] = one(good && rxMcast[p] && !rxBcast[p] && !rxControl[p]);
            incAmt[p][13] = one(good && !rxMcast[p] && !rxBcast[p]);
            incAmt[p][14] = one(len == LEN_MIN);
            incAmt[p][15] = one(len > LEN_MIN && len <= LEN_BIN1_MAX);
            incAmt[p][16] = one(len > LEN_BIN1_MAX && len <= LEN_BIN2_MAX);
            incAmt[p][17] = one(len > LEN_BIN2_MAX && len <= LEN_BIN3_MAX);
            incAmt[p][18] = one(len > LEN_BIN3_MAX && len <= LEN_BIN4_MAX);
            incAmt[p][19] = one(len > LEN_BIN4_MAX && len <= sizeLimit);
         end
         if (txDone[p] && txGood[p]) begin
            incAmt[p][20] = txHighPrio[p] ? '0 : txLength[p];
            incAmt[p][21] = txHighPrio[p] ? txLength[p] : '0;
            incAmt[p][24] = one(txBcast[p] && !txMcast[p]);
         end
         incAmt[p][22] = one(txLateCollide[p]);
         incAmt[p][23] = one(txDone[p] && txPause[p]);
      end
   end

   // ----------------------------------------------------------------
   // counter storage
   // ----------------------------------------------------------------
   // a read clears the count but keeps an event of the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NPORTS; p++) begin
            for (int c = 0; c < NCTRS; c++) begin
               mibCount[p][c] <= '0;
               mibOvf[p][c]   <= 1'b0;
            end
         end
      end else begin
         for (int p = 0; p < NPORTS; p++) begin
            for (int c = 0; c < NCTRS; c++) begin
               if (clrHit && clrPort == 3'(p) && clrCtr == 5'(c)) begin
                  mibCount[p][c] <= CNT_W'(incAmt[p][c]);
                  mibOvf[p][c]   <= 1'b0;
               end else begin
                  // the carry sets a sticky overflow; the count itself wraps
                  {mibOvf[p][c], mibCount[p][c]} <=
                     {mibOvf[p][c], CNT_W'(0)}
                     | ({1'b0, mibCount[p][c]} + (CNT_W+1)'(incAmt[p][c]));
               end
            end
         end
      end
   end

endmodule : mtmr_readout

// >>> mtmr_readout_sva.sv
module mtmr_readout_sva
   import mtmr_pkg::*;
(
   // clock and reset
   input wire logic                             core_clk,
   input wire logic                             rst,
   // register bus
   input wire logic [mtmr_pkg::ADDR_W-1:0]      address,
   input wire logic                             read,
   input wire logic                             write,
   input wire logic [31:0]                      writedata,
   input wire logic [3:0]                       byteenable,
   input wire logic [31:0]                      readdata,
   input wire logic                             waitrequest,
   // table fetch
   input wire logic                             tableRdReq,
   input wire logic [9:0]                       tableRdIndex,
   input wire logic                             tableRdAck
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sel;
   logic       trig;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // select shadow, so trigger checks know the mode
   // ----------------------------------------
   assign trig = write && !waitrequest && byteenable[0] && address == IDX_TRIGGER;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) sel <= SEL_RESET;
      else if (write && !waitrequest && byteenable[0] && address == IDX_SELECT) sel <= writedata[7:0];
   end
   sequence s_take; (read || write) && waitrequest; endsequence
   sequence s_answer; !waitrequest ##1 waitrequest; endsequence
   property p_answer; s_take |=> s_answer; endproperty
   property p_idle; !(read || write) && waitrequest |=> waitrequest; endproperty
   property p_trig;
      trig && (sel & SEL_DYN_MASK) == SEL_DYN_CODE |=> tableRdReq && tableRdIndex == {sel[1:0], $past(writedata[7:0])};
   endproperty
   property p_hold; tableRdReq && !tableRdAck && !trig |=> tableRdReq; endproperty
   property p_drop; tableRdReq && tableRdAck && !trig |=> !tableRdReq; endproperty
   property p_upper; read && !waitrequest |-> readdata[31:8] == 24'h00_0000; endproperty
   property p_pend; read && !waitrequest && address == 7'h72 && tableRdReq |-> readdata[7]; endproperty
   property p_ready;
      read && !waitrequest && address == 7'h72 && !tableRdReq && !$past(tableRdReq) |-> !readdata[7];
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer not one cycle");
   a_idle: assert property (p_idle) else $error("answer without request");
   a_trig: assert property (p_trig) else $error("trigger did not start fetch");
   a_hold: assert property (p_hold) else $error("fetch dropped before ack");
   a_drop: assert property (p_drop) else $error("fetch held after ack");
   a_upper: assert property (p_upper) else $error("upper read bits set");
   a_pend: assert property (p_pend) else $error("pending entry shown ready");
   a_ready: assert property (p_ready) else $error("settled entry shown not ready");
endmodule : mtmr_readout_sva

// >>> mtmr_table_model.sv
module mtmr_table_model (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // fetch port
   input  wire logic        tableRdReq,
   input  wire logic [9:0]  tableRdIndex,
   output logic             tableRdAck,
   output logic [1:0]       tableRdStamp,
   output logic [2:0]       tableRdPort,
   output logic [6:0]       tableRdFid,
   output logic [47:0]      tableRdMac,
   output logic [10:0]      tableCount,
   // bench knobs: answer delay and occupancy
   input  wire logic [7:0]  dly,
   input  wire logic [10:0] count
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  waitCnt;
   logic [9:0]  k;
   logic [59:0] ent;
   assign tableCount = count;
   // entry content is made here only; the host side has no path to change it
   assign ent = {k[1:0], 3'(k % 10'h005), k[6:0], k, 38'h15_5555_5555};
   // outside the ack cycle show the inverse, so a stale sample cannot pass
   assign {tableRdStamp, tableRdPort, tableRdFid, tableRdMac} = tableRdAck ? ent : ~ent;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tableRdAck <= 1'b0;
         waitCnt <= 8'h00;
         k <= 10'h000;
      end else begin
         tableRdAck <= 1'b0;
         if (tableRdReq && !tableRdAck) begin
            k <= tableRdIndex;
            if (waitCnt >= dly) tableRdAck <= 1'b1;
            else waitCnt <= waitCnt + 8'h01;
         end else waitCnt <= 8'h00;
      end
   end
endmodule : mtmr_table_model

// >>> test_mac_table_and_mib_readout.sv
module test_mac_table_and_mib_readout import mtmr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, chkRd = 1'b0;
   logic [ADDR_W-1:0] address = 7'h00;
   logic [31:0] writedata = 32'h0000_0000, readdata, expQ[$];
   logic [3:0] byteenable = 4'hF;
   logic waitrequest, tableRdReq, tableRdAck;
   logic [9:0] tableRdIndex;
   logic [1:0] tableRdStamp;
   logic [2:0] tableRdPort;
   logic [6:0] tableRdFid;
   logic [47:0] tableRdMac;
   logic [10:0] tableCount, count = 11'h000;
   logic [7:0] dly = 8'h00;
   logic [NPORTS-1:0] rxDone, rxHighPrio, rxCrcOk, rxSymbolBad, rxMisaligned, rxControl, rxPauseOk, rxBcast, rxMcast;
   logic [NPORTS-1:0] txDone, txHighPrio, txGood, txPause, txBcast, txMcast, txLateCollide;
   logic [NPORTS-1:0][LEN_W-1:0] rxLength, txLength;
   int failures, testsRun, cyc, cnt[NPORTS][32];
   int lim = 1522;
   logic huge = 1'b0;
   always #50 core_clk = ~core_clk;
   mtmr_readout DUT (.core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .tableRdReq(tableRdReq), .tableRdIndex(tableRdIndex), .tableRdAck(tableRdAck), .tableRdStamp(tableRdStamp),
      .tableRdPort(tableRdPort), .tableRdFid(tableRdFid), .tableRdMac(tableRdMac), .tableCount(tableCount),
      .rxDone(rxDone), .rxLength(rxLength), .rxHighPrio(rxHighPrio), .rxCrcOk(rxCrcOk), .rxSymbolBad(rxSymbolBad),
      .rxMisaligned(rxMisaligned), .rxControl(rxControl), .rxPauseOk(rxPauseOk), .rxBcast(rxBcast),
      .rxMcast(rxMcast), .txDone(txDone), .txLength(txLength), .txHighPrio(txHighPrio), .txGood(txGood),
      .txPause(txPause), .txBcast(txBcast), .txMcast(txMcast), .txLateCollide(txLateCollide));
   mtmr_table_model table0 (.core_clk(core_clk), .rst(rst), .tableRdReq(tableRdReq), .tableRdIndex(tableRdIndex),
      .tableRdAck(tableRdAck), .tableRdStamp(tableRdStamp), .tableRdPort(tableRdPort), .tableRdFid(tableRdFid),
      .tableRdMac(tableRdMac), .tableCount(tableCount), .dly(dly), .count(count));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task automatic cmp(input logic [31:0] e, input logic [31:0] g);
      testsRun++;
      if (g !== e) begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp
   // hold the request until waitrequest is seen low, then release
   task automatic busDo(input logic [6:0] a, input logic w, input logic [7:0] d, input logic c, output logic [7:0] q);
      @(posedge core_clk);
      {address, read, write, writedata, chkRd} <= {a, !w, w, 24'h00_0000, d, c};
      do @(posedge core_clk); while (waitrequest !== 1'b0);
      q = readdata[7:0];
      {read, write, chkRd} <= 3'h0;
   endtask : busDo
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      busDo(a, 1'b1, d, 1'b0, q);
   endtask : wr
   task automatic rdChk(input logic [6:0] a, input logic [31:0] e);
      logic [7:0] q;
      expQ.push_back(e);
      busDo(a, 1'b0, 8'h00, 1'b1, q);
   endtask : rdChk
   always @(posedge core_clk) if (read && !waitrequest && chkRd) cmp(expQ.pop_front(), readdata);
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 50000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic tblRead(input logic [10:0] n, input logic [7:0] s, input logic [7:0] ix, input logic [7:0] d);
      logic [71:0] e;
      logic [9:0]  k;
      logic [7:0]  q;
      int t;
      k = {s[1:0], ix};
      count <= n;
      dly <= d;
      e = {n == 11'h000, n == 11'h000 ? 10'h000 : 10'(n - 11'h001), k[1:0], 3'(k % 10'h005), 1'b0, k[6:0], k,
         38'h15_5555_5555};
      wr(IDX_SELECT, s);
      wr(IDX_TRIGGER, ix);
      t = 0;
      do begin
         busDo(7'h72, 1'b0, 8'h00, 1'b0, q);
         t++;
      end while (q[7] === 1'b1 && t < 60);
      if (d > 8'h08) cmp(32'h0000_0001, {31'h0000_0000, t > 1});
      for (int i = 0; i < 9; i++) rdChk(IDX_DATA_FIRST + 7'(i), {24'h00_0000, e[71-8*i -: 8]});
   endtask : tblRead
   // one frame each way on one port; other ports stay quiet this cycle
   task automatic frame(input int p);
      logic [LEN_W-1:0] rl, tl;
      logic hp, th, tg, tp, lc, ok, cr, sy, ma, ct, pa, bc, mc, tb, tm, inr;
      logic [34:0] rq;
      logic [9:0] tq;
      rl = 11'(40 + $urandom % 1960);
      tl = 11'(64 + $urandom % 1459);
      {hp, th, tg, tp, lc} = 5'($urandom);
      rq = 35'({$urandom, $urandom});
      tq = 10'($urandom);
      {cr, sy, ma, ct, pa, bc, mc} = {rq[30+p], rq[25+p], rq[20+p], rq[15+p], rq[10+p], rq[5+p], rq[p]};
      {tb, tm} = {tq[5+p], tq[p]};
      ok = cr && !sy && !ma;
      inr = rl >= 64 && rl <= lim;
      @(posedge core_clk);
      {rxDone, txDone} <= {2{5'(1 << p)}};
      rxLength[p] <= rl;
      txLength[p] <= tl;
      {rxHighPrio, txHighPrio, txGood, txPause} <= {{5{hp}}, {5{th}}, {5{tg}}, {5{tp}}};
      {rxCrcOk, rxSymbolBad, rxMisaligned, rxControl, rxPauseOk, rxBcast, rxMcast} <= rq;
      {txBcast, txMcast} <= tq;
      txLateCollide <= {5{lc}} & 5'(1 << p);
      cnt[p][hp] += rl;
      if (inr) cnt[p][rl == 64 ? 14 : rl < 128 ? 15 : rl < 256 ? 16 : rl < 512 ? 17 :
         rl < 1024 ? 18 : 19]++;
      cnt[p][2] += int'(rl < 64 && ok);
      cnt[p][3] += int'(rl < 64 && !ok);
      cnt[p][4] += int'(rl > lim && ok);
      cnt[p][5] += int'(huge ? rl > 1916 : rl > lim && !ok);
      cnt[p][6] += int'(inr && sy);
      cnt[p][7] += int'(inr && !cr && !ma);
      cnt[p][8] += int'(inr && !cr && ma);
      cnt[p][9] += int'(ct);
      cnt[p][10] += int'(pa && ct && cr && rl >= 64);
      cnt[p][11] += int'(ok && bc && !mc);
      cnt[p][12] += int'(ok && mc && !bc && !ct);
      cnt[p][13] += int'(ok && !mc && !bc);
      cnt[p][24] += int'(tg && tb && !tm);
      if (tg) cnt[p][20 + th] += tl;
      if (tp) cnt[p][23]++;
      if (lc) cnt[p][22]++;
      @(posedge core_clk);
      {rxDone, txDone, txLateCollide} <= 15'h0000;
   endtask : frame
   task automatic ctrRead(input int p, input int c);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (p < NPORTS) begin
         w = {2'b01, 30'(cnt[p][c])};
         cnt[p][c] = 0;
      end
      wr(IDX_TRIGGER, 8'(p * 32 + c));
      for (int i = 0; i < 4; i++) rdChk(IDX_DATA_FIRST + 7'(5 + i), {24'h00_0000, w[31-8*i -: 8]});
   endtask : ctrRead
   initial begin
      void'($urandom(32'h48fc_b890));
      {rxDone, rxHighPrio, rxCrcOk, rxSymbolBad, rxMisaligned, rxControl, rxPauseOk, rxBcast, rxMcast} = '0;
      {txDone, txHighPrio, txGood, txPause, txBcast, txMcast, txLateCollide, rxLength, txLength} = '0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      rdChk(IDX_DATA_FIRST, 32'h0000_0080);
      rdChk(7'h71, 32'h0000_0000);
      wr(IDX_DATA_FIRST, 8'h55);
      rdChk(IDX_DATA_FIRST, 32'h0000_0080);
      rdChk(7'h7F, 32'h0000_0000);
      tblRead(11'h000, 8'h18, 8'h00, 8'h00);
      tblRead(11'h001, 8'h19, 8'h01, 8'h14);
      tblRead(11'h002, 8'h1B, 8'hFF, 8'h02);
      tblRead(11'h400, 8'h18, 8'h05, 8'h00);
      repeat (4) tblRead(11'($urandom % 1025), 8'h18 | 8'($urandom % 4), 8'($urandom), 8'($urandom % 4));
      wr(IDX_SELECT, SEL_MIB_CODE);
      repeat (60) frame($urandom % NPORTS);
      for (int p = 0; p < NPORTS; p++) for (int c = 0; c < 26; c++) ctrRead(p, c);
      ctrRead(0, 0);
      wr(IDX_CONFIG, 8'h03);
      rdChk(IDX_CONFIG, 32'h0000_0003);
      lim = 1536;
      huge = 1'b1;
      repeat (60) frame($urandom % NPORTS);
      for (int p = 0; p < NPORTS; p++) for (int c = 0; c < 26; c++) ctrRead(p, c);
      ctrRead(5, 0);
      report_and_stop();
   end
endmodule : test_mac_table_and_mib_readout
bind mtmr_readout mtmr_readout_sva chk (.core_clk(core_clk), .rst(rst), .address(address), .read(read),
   .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .tableRdReq(tableRdReq), .tableRdIndex(tableRdIndex), .tableRdAck(tableRdAck));
